/* core/dmsb_pkg.sv */
package dmsb_pkg;

  // ==========================================================================
  // Address map.
  localparam logic [15:0] DMSB_WIN_BASE = 16'h7000;
  localparam logic [15:0] DMSB_WIN_LAST = 16'h7044;
  localparam logic [15:0] DMSB_COMM_SET_ADDR = 16'h1000;
  localparam logic [6:0] IDX_RUN_FREQ = 7'h00;
  localparam logic [6:0] IDX_SET_FREQ = 7'h01;
  localparam logic [6:0] IDX_BUS_VOLT = 7'h02;
  localparam logic [6:0] IDX_OUT_VOLT = 7'h03;
  localparam logic [6:0] IDX_OUT_CURR = 7'h04;
  localparam logic [6:0] IDX_OUT_POWER = 7'h05;
  localparam logic [6:0] IDX_OUT_TORQUE = 7'h06;
  localparam logic [6:0] IDX_IN_LEVEL = 7'h07;
  localparam logic [6:0] IDX_OUT_LEVEL = 7'h08;
  localparam logic [6:0] IDX_AI_CORR0 = 7'h09;
  localparam logic [6:0] IDX_PID_SET = 7'h0f;
  localparam logic [6:0] IDX_PID_FB = 7'h10;
  localparam logic [6:0] IDX_PULSE_KHZ = 7'h12;
  localparam logic [6:0] IDX_FB_FREQ = 7'h13;
  localparam logic [6:0] IDX_TIME_LEFT = 7'h14;
  localparam logic [6:0] IDX_AI_RAW0 = 7'h15;
  localparam logic [6:0] IDX_LINE_SPEED = 7'h18;
  localparam logic [6:0] IDX_PULSE_HZ = 7'h1b;
  localparam logic [6:0] IDX_COMM_SET = 7'h1c;
  localparam logic [6:0] IDX_ENC_FREQ = 7'h1d;
  localparam logic [6:0] IDX_MAIN_FREQ = 7'h1e;
  localparam logic [6:0] IDX_AUX_FREQ = 7'h1f;

  // ==========================================================================
  // Scaling and timing.
  localparam logic [1:0] RES_COARSE = 2'h1;
  localparam int FREQ_MAX_COUNTS = 32000;
  localparam int KHZ_MAX = 10000;
  localparam int HZ_MAX = 65535;
  localparam int TIME_LEFT_MAX = 65000;
  localparam int PID_PCT_DIV = 10000;
  localparam int CURR_SMALL_DIV = 10;
  localparam int CURR_LARGE_DIV = 100;
  localparam int AI_GAIN_SHIFT = 12;
  localparam int PULSES_PER_MIN_MUL = 60;
  localparam int CLK_MHZ = 200;
  localparam int PULSE_GATE_TIME_MS = 1000;
  localparam int PULSE_GATE_CYCLES = PULSE_GATE_TIME_MS * CLK_MHZ * 1000;
  localparam logic [23:0] PULSE_CNT_MAX = 24'hffffff;
  localparam logic [15:0] RD_DATA_RESET = 16'h0000;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic signed [31:0] run_freq;
    logic signed [31:0] set_freq;
    logic signed [31:0] fb_freq;
    logic signed [31:0] enc_freq;
    logic signed [31:0] main_freq;
    logic signed [31:0] aux_freq;
    logic [15:0] bus_voltage;
    logic [15:0] out_voltage;
    logic [31:0] out_current_ma;
    logic [15:0] out_power;
    logic [15:0] out_torque;
    logic [15:0] pid_set_pct;
    logic [15:0] pid_fb_pct;
    logic [15:0] time_left;
    logic [2:0][15:0] ai_raw;
    logic [15:0] ai2_ma_raw;
  } dmsb_meas_s;

  typedef struct packed {
    logic analog_two_unit_select;
    logic [1:0] freq_resolution_select;
    logic [15:0] pid_display_scale;
    logic [15:0] pulses_per_metre;
    logic timed_run_enable;
    logic large_drive;
    logic [2:0][15:0] ai_gain;
    logic [2:0][15:0] ai_offset;
  } dmsb_cfg_s;

  typedef struct packed {
    logic [9:0] input_terminal;
    logic [4:0] virtual_in_terminal;
    logic out_three;
    logic relay_one;
    logic relay_two;
    logic out_one;
    logic out_two;
    logic [4:0] virtual_out_terminal;
  } dmsb_pins_s;

  typedef struct packed {
    logic rd_req;
    logic wr_req;
    logic [15:0] addr;
    logic [15:0] wr_data;
  } dmsb_host_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] count;
    logic [16:0] rem;
    logic [31:0] quo;
    logic [15:0] divisor;
  } dmsb_div_state_s;

  typedef struct packed {
    dmsb_pins_s pin_meta;
    dmsb_pins_s pin_sync;
    logic pulse_meta;
    logic pulse_sync;
    logic pulse_prev;
    logic [31:0] gate_cnt;
    logic [23:0] pulse_cnt;
    logic [23:0] pulse_total;
    logic [15:0] pulse_hz;
    logic [15:0] pulse_khz;
    logic div_start;
    logic [15:0] line_speed;
    logic [15:0] comm_set;
    logic rd_valid;
    logic rd_err;
    logic [15:0] rd_data;
  } dmsb_state_s;

endpackage : dmsb_pkg

/* core/dmsb_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module dmsb_divider
  import dmsb_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Request.
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [15:0] divisor,
  // Result.
  output logic done,
  output logic [31:0] quotient
);

  dmsb_div_state_s st_reg;
  dmsb_div_state_s st_next;
  logic [16:0] trial;

  // ==========================================================================
  // Restoring division, one quotient bit per cycle; slow but tiny.
  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    trial = {st_reg.rem[15:0], st_reg.quo[31]};
    if (start && !st_reg.busy)
    begin
      st_next.busy = 1'b1;
      st_next.count = 6'h00;
      st_next.rem = 17'h00000;
      st_next.quo = dividend;
      st_next.divisor = divisor;
    end
    else if (st_reg.busy)
    begin
      if (trial >= {1'b0, st_reg.divisor})
      begin
        st_next.rem = trial - {1'b0, st_reg.divisor};
        st_next.quo = {st_reg.quo[30:0], 1'b1};
      end
      else
      begin
        st_next.rem = trial;
        st_next.quo = {st_reg.quo[30:0], 1'b0};
      end
      st_next.count = st_reg.count + 6'h01;
      if (st_reg.count == 6'h1f)
      begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign done = st_reg.done;
  assign quotient = st_reg.quo;

endmodule : dmsb_divider
`default_nettype wire

/* core/dmsb_status_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module dmsb_status_bank
  import dmsb_pkg::*;
#(
  parameter int GATE_CYCLES = PULSE_GATE_CYCLES
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Drive measurements and settings, same clock domain.
  input wire dmsb_meas_s meas,
  input wire dmsb_cfg_s cfg,
  // Terminal levels and pulse pin, asynchronous.
  input wire dmsb_pins_s pins,
  input wire logic pulse_input_terminal,
  // Host access after link framing.
  input wire dmsb_host_s host,
  output logic rd_valid,
  output logic rd_err,
  output logic [15:0] rd_data
);

  dmsb_state_s st_reg;
  dmsb_state_s st_next;
  logic div_done;
  logic [31:0] div_quo;
  logic [2:0][15:0] ai_sel;
  logic [2:0][15:0] ai_corr;
  logic [6:0] idx;
  logic in_window;

  // ==========================================================================
  // Helpers.

  // Clamp an unsigned value to the limit lim within the 16-bit field range.
  function automatic logic [15:0] sat_u16(input logic [31:0] v, input int lim);
    logic [31:0] l;
    l = 32'(lim);
    sat_u16 = (v > l) ? l[15:0] : v[15:0];
  endfunction : sat_u16

  // Raw frequency is in 0.01 Hz; coarse resolution drops one decimal.
  function automatic logic [15:0] fmt_freq(input logic signed [31:0] raw,
                                           input logic [1:0] res,
                                           input logic abs_en);
    logic signed [31:0] v;
    v = (res == RES_COARSE) ? raw / 32'sd10 : raw;
    if (abs_en && v < 0)
      v = -v;
    if (v > FREQ_MAX_COUNTS)
      v = FREQ_MAX_COUNTS;
    else if (v < -FREQ_MAX_COUNTS)
      v = -FREQ_MAX_COUNTS;
    fmt_freq = v[15:0];
  endfunction : fmt_freq

  // ==========================================================================
  // Analog correction per channel: gain in 4.12 fixed point, then offset.
  for (genvar i = 0; i < 3; i++)
  begin : g_ai
    logic signed [32:0] prod;
    logic signed [32:0] corr;
    assign ai_sel[i] = (i == 1 && cfg.analog_two_unit_select) ? meas.ai2_ma_raw : meas.ai_raw[i];
    assign prod = $signed(ai_sel[i]) * $signed({1'b0, cfg.ai_gain[i]});
    assign corr = (prod >>> AI_GAIN_SHIFT) + 33'($signed(cfg.ai_offset[i]));
    // Saturate so a bad gain cannot wrap a reading through zero.
    assign ai_corr[i] = (corr > 33'sd32767) ? 16'h7fff :
                        (corr < -33'sd32768) ? 16'h8000 : corr[15:0];
  end

  // ==========================================================================
  // Line speed divider.
  dmsb_divider u_div (
    .clk(clk),
    .resetn(resetn),
    .start(st_reg.div_start),
    .dividend(32'(st_reg.pulse_total) * 32'(PULSES_PER_MIN_MUL)),
    .divisor(cfg.pulses_per_metre),
    .done(div_done),
    .quotient(div_quo)
  );

  assign idx = 7'(host.addr - DMSB_WIN_BASE);
  assign in_window = (host.addr >= DMSB_WIN_BASE) && (host.addr <= DMSB_WIN_LAST);

  // ==========================================================================
  // Next state: synchronisers, pulse gate, setpoint capture and read answer.
  always_comb
  begin
    logic pulse_edge;
    logic [15:0] rdv;
    logic [31:0] curr;
    pulse_edge = 1'b0;
    rdv = RD_DATA_RESET;
    curr = 32'h0;
    st_next = st_reg;
    st_next.pin_meta = pins;
    st_next.pin_sync = st_reg.pin_meta;
    st_next.pulse_meta = pulse_input_terminal;
    st_next.pulse_sync = st_reg.pulse_meta;
    st_next.pulse_prev = st_reg.pulse_sync;
    st_next.div_start = 1'b0;
    pulse_edge = st_reg.pulse_sync && !st_reg.pulse_prev;
    // A one-second gate counts rising edges, so the count is directly in Hz.
    if (st_reg.gate_cnt == 32'(GATE_CYCLES - 1))
    begin
      st_next.gate_cnt = 32'h0;
      st_next.pulse_cnt = 24'h0;
      st_next.pulse_total = st_reg.pulse_cnt;
      st_next.pulse_hz = sat_u16(32'(st_reg.pulse_cnt), HZ_MAX);
      st_next.pulse_khz = sat_u16(32'(st_reg.pulse_cnt) / 32'd10, KHZ_MAX);
      st_next.div_start = 1'b1;
    end
    else
    begin
      st_next.gate_cnt = st_reg.gate_cnt + 32'h1;
      if (pulse_edge && st_reg.pulse_cnt != PULSE_CNT_MAX)
        st_next.pulse_cnt = st_reg.pulse_cnt + 24'h1;
    end
    // A zero pulses-per-metre setting reads as zero speed, not all ones.
    if (div_done)
      st_next.line_speed = (cfg.pulses_per_metre == 16'h0) ? 16'h0 : sat_u16(div_quo, HZ_MAX);
    // Only the setpoint address takes host data; window writes are dropped.
    if (host.wr_req && host.addr == DMSB_COMM_SET_ADDR)
      st_next.comm_set = host.wr_data;
    curr = cfg.large_drive ? meas.out_current_ma / 32'(CURR_LARGE_DIV)
                           : meas.out_current_ma / 32'(CURR_SMALL_DIV);
    // Read mux; unknown indices inside the window read zero.
    unique case (idx)
      IDX_RUN_FREQ: rdv = fmt_freq(meas.run_freq, cfg.freq_resolution_select, 1'b1);
      IDX_SET_FREQ: rdv = fmt_freq(meas.set_freq, cfg.freq_resolution_select, 1'b1);
      IDX_BUS_VOLT: rdv = meas.bus_voltage;
      IDX_OUT_VOLT: rdv = meas.out_voltage;
      IDX_OUT_CURR: rdv = sat_u16(curr, HZ_MAX);
      IDX_OUT_POWER: rdv = meas.out_power;
      IDX_OUT_TORQUE: rdv = meas.out_torque;
      IDX_IN_LEVEL: rdv = {1'b0, st_reg.pin_sync.virtual_in_terminal, st_reg.pin_sync.input_terminal};
      IDX_OUT_LEVEL: rdv = {6'h00, st_reg.pin_sync.virtual_out_terminal, st_reg.pin_sync.out_two,
                            st_reg.pin_sync.out_one, st_reg.pin_sync.relay_two, st_reg.pin_sync.relay_one,
                            st_reg.pin_sync.out_three};
      IDX_AI_CORR0: rdv = ai_corr[0];
      IDX_AI_CORR0 + 7'h1: rdv = ai_corr[1];
      IDX_AI_CORR0 + 7'h2: rdv = ai_corr[2];
      IDX_PID_SET: rdv = sat_u16(32'(meas.pid_set_pct) * 32'(cfg.pid_display_scale) / 32'(PID_PCT_DIV), HZ_MAX);
      IDX_PID_FB: rdv = sat_u16(32'(meas.pid_fb_pct) * 32'(cfg.pid_display_scale) / 32'(PID_PCT_DIV), HZ_MAX);
      IDX_PULSE_KHZ: rdv = st_reg.pulse_khz;
      IDX_FB_FREQ: rdv = fmt_freq(meas.fb_freq, cfg.freq_resolution_select, 1'b0);
      IDX_TIME_LEFT: rdv = cfg.timed_run_enable ? sat_u16(32'(meas.time_left), TIME_LEFT_MAX) : 16'h0;
      IDX_AI_RAW0: rdv = ai_sel[0];
      IDX_AI_RAW0 + 7'h1: rdv = ai_sel[1];
      IDX_AI_RAW0 + 7'h2: rdv = ai_sel[2];
      IDX_LINE_SPEED: rdv = st_reg.line_speed;
      IDX_PULSE_HZ: rdv = st_reg.pulse_hz;
      IDX_COMM_SET: rdv = st_reg.comm_set;
      IDX_ENC_FREQ: rdv = fmt_freq(meas.enc_freq, cfg.freq_resolution_select, 1'b0);
      IDX_MAIN_FREQ: rdv = fmt_freq(meas.main_freq, cfg.freq_resolution_select, 1'b0);
      IDX_AUX_FREQ: rdv = fmt_freq(meas.aux_freq, cfg.freq_resolution_select, 1'b0);
      default: rdv = RD_DATA_RESET;
    endcase
    // Reads only sample; no field is touched by a read.
    st_next.rd_valid = host.rd_req;
    st_next.rd_err = host.rd_req && !in_window;
    if (host.rd_req)
      st_next.rd_data = in_window ? rdv : RD_DATA_RESET;
  end

  // State register.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign rd_valid = st_reg.rd_valid;
  assign rd_err = st_reg.rd_err;
  assign rd_data = st_reg.rd_data;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_read_answer: assert property (host.rd_req |=> rd_valid && (rd_err == !$past(in_window)))
    else $error("read not answered next cycle");
  a_in_level_map: assert property (host.rd_req && in_window && idx == IDX_IN_LEVEL
      |=> rd_data == {1'b0, $past(st_reg.pin_sync.virtual_in_terminal), $past(st_reg.pin_sync.input_terminal)})
    else $error("input level word mismatch");
  a_in_level_top: assert property (rd_valid && $past(idx) == IDX_IN_LEVEL |-> !rd_data[15])
    else $error("input level word top bit set");
  a_out_level_map: assert property (host.rd_req && in_window && idx == IDX_OUT_LEVEL
      |=> rd_data[15:10] == 6'h00 && rd_data[0] == $past(st_reg.pin_sync.out_three)
          && rd_data[9:5] == $past(st_reg.pin_sync.virtual_out_terminal))
    else $error("output level word mismatch");
  a_ai2_unit: assert property (host.rd_req && idx == IDX_AI_RAW0 + 7'h1 && in_window && cfg.analog_two_unit_select
      |=> rd_data == $past(meas.ai2_ma_raw))
    else $error("analog two unit select ignored");
  a_khz_range: assert property (st_reg.pulse_khz <= 16'(KHZ_MAX))
    else $error("pulse kHz view out of range");
  a_khz_hz_pair: assert property ($rose(st_reg.div_start) && st_reg.pulse_hz != 16'hffff
      |-> st_reg.pulse_khz == st_reg.pulse_hz / 16'd10)
    else $error("pulse views disagree");
  a_zero_ppm: assert property (div_done && cfg.pulses_per_metre == 16'h0 |=> st_reg.line_speed == 16'h0)
    else $error("line speed nonzero with zero pulses per metre");
  a_comm_capture: assert property (host.wr_req && host.addr == DMSB_COMM_SET_ADDR
      |=> st_reg.comm_set == $past(host.wr_data))
    else $error("setpoint write not captured");
  a_window_write: assert property (host.wr_req && in_window |=> $stable(st_reg.comm_set))
    else $error("window write changed a field");
  a_time_off: assert property (host.rd_req && in_window && idx == IDX_TIME_LEFT && !cfg.timed_run_enable
      |=> rd_data == 16'h0)
    else $error("time left shown while timing off");

  c_read_error: cover property (host.rd_req && !in_window ##1 rd_err);
  c_line_speed: cover property (div_done && cfg.pulses_per_metre != 16'h0);
  c_comm_write: cover property (host.wr_req && host.addr == DMSB_COMM_SET_ADDR);
  c_back_to_back: cover property (host.rd_req [*3]);

endmodule : dmsb_status_bank
`default_nettype wire

/* dv/dmsb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Host computer model: single-word reads and writes after link framing.
module dmsb_host_model
  import dmsb_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Requests towards the bank.
  output var dmsb_host_s host,
  // Answers from the bank.
  input wire logic rd_valid,
  input wire logic rd_err,
  input wire logic [15:0] rd_data
);
  int hangs = 0;

  initial host = '0;

  // One read: the request stands for its single taking edge, then the answer is waited for.
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e);
    int n;
    @(posedge clk);
    host.rd_req <= 1'b1;
    host.addr <= a;
    @(posedge clk);
    host.rd_req <= 1'b0;
    host.addr <= ~a;  // A released address never shows its last value.
    #1;
    n = 0;
    while (rd_valid !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8)
      hangs++;
    d = rd_data;
    e = rd_err;
  endtask : rd

  // One write: no answer comes back, so the strobe simply stands one cycle.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    host.wr_req <= 1'b1;
    host.addr <= a;
    host.wr_data <= d;
    @(posedge clk);
    host.wr_req <= 1'b0;
    host.addr <= ~a;
    host.wr_data <= ~d;
  endtask : wr
endmodule : dmsb_host_model
`default_nettype wire

/* dv/dmsb_status_bank_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the monitoring register bank.
module dmsb_status_bank_test;
  import dmsb_pkg::*;
  localparam int GATE = 100;  // Short gate so pulse counts settle within a few hundred cycles.
  logic clk = 1'b0;
  logic resetn = 1'b0;
  dmsb_meas_s meas = '0;
  dmsb_cfg_s cfg = '0;
  dmsb_pins_s pins = '0;
  logic pulse = 1'b0;
  logic pulse_on = 1'b0;
  logic [3:0] phase = 4'h0;
  dmsb_host_s host;
  logic rd_valid;
  logic rd_err;
  logic [15:0] rd_data;
  int failures = 0;
  int num_checks = 0;

  // ==========================================================================
  // Clock, device and host.
  initial forever #2.5 clk = ~clk;

  dmsb_status_bank #(.GATE_CYCLES(GATE)) u_dut (.clk(clk), .resetn(resetn), .meas(meas), .cfg(cfg),
    .pins(pins), .pulse_input_terminal(pulse), .host(host), .rd_valid(rd_valid), .rd_err(rd_err),
    .rd_data(rd_data));

  dmsb_host_model u_host (.clk(clk), .host(host), .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data));

  // Pulse source with a ten-cycle period, so each gate holds exactly ten rising edges.
  always @(posedge clk)
  begin
    phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
    pulse <= pulse_on & (phase < 4'h5);
  end

  // ==========================================================================
  // Comparison and closing tasks.
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_flag(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flag

  task automatic expect_rd(input logic [15:0] a, input logic err, input logic [15:0] exp);
    logic [15:0] d;
    logic e;
    u_host.rd(a, d, e);
    check_flag($sformatf("error flag at %h", a), err, e);
    check_word($sformatf("word at %h", a), exp, d);
  endtask : expect_rd

  task automatic test_done();
    failures += u_host.hangs;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Scenarios.
  task automatic test_window();
    check_flag("idle valid", 1'b0, rd_valid);
    check_word("idle data", 16'h0000, rd_data);
    expect_rd(16'h6fff, 1'b1, 16'h0000);
    expect_rd(16'h7045, 1'b1, 16'h0000);
    expect_rd(16'h7044, 1'b0, 16'h0000);
    $display("test_window done");
  endtask : test_window

  task automatic test_levels();
    @(posedge clk);
    pins.input_terminal <= 10'h2a5;
    pins.virtual_in_terminal <= 5'h13;
    pins.out_three <= 1'b1;
    pins.relay_two <= 1'b1;
    pins.out_one <= 1'b1;
    pins.virtual_out_terminal <= 5'h0a;
    repeat (3) @(posedge clk);
    expect_rd(16'h7007, 1'b0, {1'b0, 5'h13, 10'h2a5});
    expect_rd(16'h7007, 1'b0, {1'b0, 5'h13, 10'h2a5});
    expect_rd(16'h7008, 1'b0, {6'h00, 5'h0a, 5'b01101});
    u_host.wr(16'h7008, 16'hffff);
    expect_rd(16'h7008, 1'b0, {6'h00, 5'h0a, 5'b01101});
    $display("test_levels done");
  endtask : test_levels

  task automatic test_comm();
    u_host.wr(16'h1000, 16'h8123);
    expect_rd(16'h701c, 1'b0, 16'h8123);
    u_host.wr(16'h701c, 16'h0000);
    u_host.wr(16'h1001, 16'h0000);
    expect_rd(16'h701c, 1'b0, 16'h8123);
    $display("test_comm done");
  endtask : test_comm

  task automatic test_freq();
    logic [6:0] idx [4] = '{IDX_FB_FREQ, IDX_ENC_FREQ, IDX_MAIN_FREQ, IDX_AUX_FREQ};
    @(posedge clk);
    cfg.freq_resolution_select <= 2'h2;
    meas.run_freq <= -32'sd12345;
    meas.set_freq <= 32'sd7000;
    meas.fb_freq <= -32'sd500;
    meas.enc_freq <= -32'sd500;
    meas.main_freq <= -32'sd500;
    meas.aux_freq <= -32'sd500;
    expect_rd(16'h7000, 1'b0, 16'd12345);
    expect_rd(16'h7001, 1'b0, 16'd7000);
    foreach (idx[i]) expect_rd(16'h7000 + 16'(idx[i]), 1'b0, 16'hfe0c);
    @(posedge clk);
    cfg.freq_resolution_select <= RES_COARSE;
    expect_rd(16'h7000, 1'b0, 16'd1234);
    expect_rd(16'h7001, 1'b0, 16'd700);
    foreach (idx[i]) expect_rd(16'h7000 + 16'(idx[i]), 1'b0, 16'hffce);
    $display("test_freq done");
  endtask : test_freq

  task automatic test_scale();
    @(posedge clk);
    meas.out_current_ma <= 32'd123456;
    meas.pid_set_pct <= 16'd5000;
    meas.pid_fb_pct <= 16'hffff;
    cfg.pid_display_scale <= 16'd1000;
    meas.time_left <= 16'hffff;
    meas.ai_raw[0] <= 16'h0200;
    meas.ai_raw[1] <= 16'h0123;
    meas.ai2_ma_raw <= 16'h0456;
    cfg.ai_gain[0] <= 16'h2000;
    cfg.ai_offset[0] <= 16'h0005;
    expect_rd(16'h7004, 1'b0, 16'd12345);
    expect_rd(16'h700f, 1'b0, 16'd500);
    expect_rd(16'h7010, 1'b0, 16'd6553);
    expect_rd(16'h7014, 1'b0, 16'h0000);
    expect_rd(16'h7015, 1'b0, 16'h0200);
    expect_rd(16'h7009, 1'b0, 16'h0405);
    expect_rd(16'h7016, 1'b0, 16'h0123);
    @(posedge clk);
    cfg.large_drive <= 1'b1;
    cfg.timed_run_enable <= 1'b1;
    cfg.analog_two_unit_select <= 1'b1;
    expect_rd(16'h7004, 1'b0, 16'd1234);
    expect_rd(16'h7014, 1'b0, 16'd65000);
    expect_rd(16'h7016, 1'b0, 16'h0456);
    $display("test_scale done");
  endtask : test_scale

  task automatic test_pulse();
    @(posedge clk);
    cfg.pulses_per_metre <= 16'd3;
    pulse_on <= 1'b1;
    repeat (3 * GATE) @(posedge clk);
    expect_rd(16'h701b, 1'b0, 16'd10);
    expect_rd(16'h7012, 1'b0, 16'd1);
    expect_rd(16'h7018, 1'b0, 16'd200);
    $display("test_pulse done");
  endtask : test_pulse

  // ==========================================================================
  // Main sequence: reset held 20 cycles, then each scenario in turn.
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    test_window();
    test_levels();
    test_comm();
    test_freq();
    test_scale();
    test_pulse();
    test_done();
  end

  // Watchdog so a stalled run still reaches the verdict.
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule : dmsb_status_bank_test
`default_nettype wire
